// ---- rtl/amp_prot_pkg.sv ----
// Contract
// - Any protected fault other than bootstrap undervoltage puts the affected half-bridges Hi-Z and pulls shutdown low at once.
// - Faults other than overload and thermal shutdown recover by themselves.
// - Local fault disables its A+B or C+D pair; in parallel mode all four.
// - Bootstrap undervoltage disables only its half-bridge, no latch, shutdown stays high.
// - Pin-short check runs only at supply start-up, never later.
// - A found short holds all half-bridges Hi-Z until it clears, then start-up continues.
// - Pin-short check tests shorts to ground first, then shorts to the stage supply.
// - Check duration scales with filter capacitance, about 15 ms per microfarad.
// - During the check shutdown is held low and the reset pin is ignored.
// - Toggling reset never restarts the pin-short check.
// - Check runs in bridge-tied and parallel modes, skipped in single-ended; the code always runs it, as ctrl still holds its bridge-tied reset value then.
// - Three-level: low warning above 100 C, high warning and shutdown above 155 C.
// - Thermal shutdown forces Hi-Z, shutdown low, latched until a reset.
// - Two-level: one warning above 125 C, latched shutdown above 155 C.
// - Supply undervoltage forces Hi-Z and shutdown low, resumes when supplies recover.
// - Power-on reset clears the overload state before operation starts.
// - Reset pin low forces all half-bridges Hi-Z.
// - Reset low enables weak output pulldown in bridge modes, plain Hi-Z single-ended.
// - Reset pin low forces the shutdown flag high whatever faults exist.
// - Reset rising edge clears latched overload and runs start-up, then switching.
// - Trim pin tied to regulator disables oscillator, oscillator pins become inputs.
// - Shutdown and warning flags are active-low open-drain outputs.
package amp_prot_pkg;

    localparam int CLK_PERIOD_NS  = 50;
    localparam int PSC_US_PER_UF  = 15000;
    localparam int PSC_CYC_PER_UF = PSC_US_PER_UF * 1000 / CLK_PERIOD_NS;
    localparam int START_NS       = 1000;
    localparam int START_CYC      = (START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    localparam int         CTRL_W        = 3;
    localparam int         CTRL_CFG_LSB  = 0;
    localparam int         CTRL_CFG_MSB  = 1;
    localparam int         CTRL_3LVL_BIT = 2;
    localparam logic [2:0] CTRL_RESET    = 3'h4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        CFG_BTL  = 2'h0,
        CFG_PARALLEL_BRIDGE_CONFIG = 2'h1,
        CFG_SE   = 2'h2
    } cfg_t;

    typedef enum logic [5:0] {
        ST_POR      = 6'h01,
        ST_PSC_GND  = 6'h02,
        ST_PSC_PVDD = 6'h04,
        ST_HOLD     = 6'h08,
        ST_START    = 6'h10,
        ST_RUN      = 6'h20
    } state_t;

    typedef struct packed {
        logic [14:0] zero;
        logic [3:0]  pin_level;
        logic        osc_slave;
        logic        thermal_latched;
        logic        overload_latched;
        logic [3:0]  hiz;
        logic [5:0]  state;
    } status_t;

endpackage

// ---- rtl/sync_bits.sv ----
module sync_bits #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                meta[i] <= 1'b0;
                dout[i] <= 1'b0;
            end else begin
                meta[i] <= din[i];
                dout[i] <= meta[i];
            end
        end
    end
endmodule // sync_bits

// ---- rtl/amp_fault_protection_ctrl.sv ----
module amp_fault_protection_ctrl
    import amp_prot_pkg::*;
#(
    parameter int unsigned PSC_STEP_CYCLES = PSC_CYC_PER_UF / 2,
    parameter int          ADDR_W          = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              reset_pin_n,
    input  wire logic [3:0]        local_fault,
    input  wire logic [3:0]        overload_trip,
    input  wire logic [3:0]        bootstrap_uv,
    input  wire logic              undervoltage_trip,
    input  wire logic              temp_above_low,
    input  wire logic              temp_above_warn,
    input  wire logic              temp_above_shut,
    input  wire logic              short_to_gnd,
    input  wire logic              short_to_supply,
    input  wire logic              freq_trim_pin_at_reg,
    input  wire logic              shutdown_flag_n_i,
    input  wire logic              temp_warn_low_n_i,
    input  wire logic              temp_warn_high_n_i,
    input  wire logic              temp_warn_n_i,
    output logic                   shutdown_flag_n_o,
    output logic                   shutdown_flag_n_oe,
    output logic                   temp_warn_low_n_o,
    output logic                   temp_warn_low_n_oe,
    output logic                   temp_warn_high_n_o,
    output logic                   temp_warn_high_n_oe,
    output logic                   temp_warn_n_o,
    output logic                   temp_warn_n_oe,
    output logic [3:0]             hb_hiz,
    output logic [3:0]             hb_pulldown,
    output logic                   osc_internal_en,
    output logic                   osc_pins_input
);

    if (PSC_STEP_CYCLES < 1 || ADDR_W < 4) begin : g_bad_param
        $error("amp_fault_protection_ctrl: unsupported parameter value");
    end

    localparam int NSYNC = 20;

    logic [NSYNC-1:0] sync_in;
    logic [NSYNC-1:0] sync_out;
    logic             rst_s;
    logic [3:0]       local_s;
    logic [3:0]       ovl_s;
    logic [3:0]       bst_s;
    logic             uv_s;
    logic             t_low_s;
    logic             t_warn_s;
    logic             t_shut_s;
    logic             sh_gnd_s;
    logic             sh_sup_s;
    logic             strap_s;

    // Detector outputs are asynchronous to this clock
    assign sync_in = {reset_pin_n, local_fault, overload_trip, bootstrap_uv,
                      undervoltage_trip, temp_above_low, temp_above_warn,
                      temp_above_shut, short_to_gnd, short_to_supply,
                      freq_trim_pin_at_reg};

    sync_bits #(.WIDTH(NSYNC)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (sync_in),
        .dout    (sync_out)
    );

    assign {rst_s, local_s, ovl_s, bst_s, uv_s, t_low_s, t_warn_s, t_shut_s,
            sh_gnd_s, sh_sup_s, strap_s} = sync_out;

    logic [CTRL_W-1:0] ctrl;
    cfg_t              cfg;
    logic              three_level;
    logic              parallel_bridge_config;
    logic              se;

    assign cfg         = cfg_t'(ctrl[CTRL_CFG_MSB:CTRL_CFG_LSB]);
    assign three_level = ctrl[CTRL_3LVL_BIT];
    assign parallel_bridge_config        = (cfg == CFG_PARALLEL_BRIDGE_CONFIG);
    assign se          = (cfg == CFG_SE);

    state_t      state;
    state_t      next_state;
    logic [31:0] cnt;
    logic        rst_prev;
    logic        rst_rise;
    logic        psc_busy;
    logic        psc_short;
    logic        step_done;
    logic        start_done;
    logic [3:0]  ovl_q;
    logic        therm_q;
    logic        osc_slave;
    logic [1:0]  por_cnt;
    logic        por_done;

    // Strap and config decisions wait until the synchronisers carry real pin levels
    assign por_done = (por_cnt == 2'd2);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_cnt <= '0;
        end else if (!por_done) begin
            por_cnt <= por_cnt + 2'd1;
        end
    end

    assign psc_busy   = (state == ST_PSC_GND) || (state == ST_PSC_PVDD);
    assign psc_short  = (state == ST_PSC_GND) ? sh_gnd_s : sh_sup_s;
    assign step_done  = (cnt == PSC_STEP_CYCLES - 1);
    assign start_done = (cnt == 32'(START_CYC - 1));
    // Edge is ignored while the pin-short check owns the stage
    assign rst_rise   = rst_s && !rst_prev && !psc_busy;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_prev <= 1'b0;
        end else begin
            rst_prev <= rst_s;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_POR: begin
                if (!por_done) begin
                    next_state = ST_POR;
                end else if (se) begin
                    next_state = rst_s ? ST_START : ST_HOLD;
                end else begin
                    next_state = ST_PSC_GND;
                end
            end
            ST_PSC_GND: begin
                if (step_done) begin
                    next_state = ST_PSC_PVDD;
                end
            end
            ST_PSC_PVDD: begin
                if (step_done) begin
                    next_state = rst_s ? ST_START : ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (rst_rise) begin
                    next_state = ST_START;
                end
            end
            ST_START: begin
                if (!rst_s) begin
                    next_state = ST_HOLD;
                end else if (start_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!rst_s) begin
                    next_state = ST_HOLD;
                end
            end
            default: next_state = ST_POR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_POR;
        end else begin
            state <= next_state;
        end
    end

    // One counter serves both check steps and the start-up delay
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= '0;
        end else if (next_state != state) begin
            cnt <= '0;
        end else if (psc_busy && (psc_short || uv_s)) begin
            cnt <= '0;
        end else if (psc_busy || state == ST_START) begin
            cnt <= cnt + 32'd1;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovl_q <= '0;
        end else if (rst_rise) begin
            ovl_q <= ovl_s;
        end else begin
            ovl_q <= ovl_q | ovl_s;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            therm_q <= 1'b0;
        end else if (rst_rise) begin
            therm_q <= t_shut_s;
        end else begin
            therm_q <= therm_q | t_shut_s;
        end
    end

    // Strap is sampled on every cycle in ST_POR, and the last sample is held after that
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_slave <= 1'b0;
        end else if (state == ST_POR) begin
            osc_slave <= strap_s;
        end
    end

    logic [3:0] loc;
    logic [3:0] grp;
    logic       fault_sd;
    logic       global_off;

    assign loc        = local_s | ovl_q;
    assign grp        = parallel_bridge_config ? {4{|loc}} : {{2{|loc[3:2]}}, {2{|loc[1:0]}}};
    assign fault_sd   = (|loc) || uv_s || therm_q;
    assign global_off = uv_s || therm_q || (state != ST_RUN);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hb_hiz      <= 4'hf;
            hb_pulldown <= 4'h0;
        end else begin
            hb_hiz      <= {4{global_off}} | grp | bst_s;
            hb_pulldown <= {4{state == ST_HOLD && !se}};
        end
    end

    // Pins are open-drain: the enable pulls the line low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shutdown_flag_n_o   <= 1'b0;
            shutdown_flag_n_oe  <= 1'b0;
            temp_warn_low_n_o   <= 1'b0;
            temp_warn_low_n_oe  <= 1'b0;
            temp_warn_high_n_o  <= 1'b0;
            temp_warn_high_n_oe <= 1'b0;
            temp_warn_n_o       <= 1'b0;
            temp_warn_n_oe      <= 1'b0;
        end else begin
            shutdown_flag_n_o   <= 1'b0;
            shutdown_flag_n_oe  <= psc_busy || (rst_s && fault_sd);
            temp_warn_low_n_o   <= 1'b0;
            temp_warn_low_n_oe  <= three_level && t_low_s;
            temp_warn_high_n_o  <= 1'b0;
            temp_warn_high_n_oe <= three_level && t_shut_s;
            temp_warn_n_o       <= 1'b0;
            temp_warn_n_oe      <= !three_level && t_warn_s;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_internal_en <= 1'b1;
            osc_pins_input  <= 1'b0;
        end else begin
            osc_internal_en <= !osc_slave;
            osc_pins_input  <= osc_slave;
        end
    end

    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              aw_ok;
    logic              w_ok;
    logic              do_write;

    assign do_write = aw_ok && w_ok && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready  <= 1'b0;
            aw_ok    <= 1'b0;
            awaddr_q <= '0;
        end else if (awvalid && awready) begin
            awready  <= 1'b0;
            aw_ok    <= 1'b1;
            awaddr_q <= awaddr;
        end else if (do_write) begin
            aw_ok <= 1'b0;
        end else if (!aw_ok && !bvalid) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready  <= 1'b0;
            w_ok    <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (wvalid && wready) begin
            wready  <= 1'b0;
            w_ok    <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end else if (do_write) begin
            w_ok <= 1'b0;
        end else if (!w_ok && !bvalid) begin
            wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl   <= CTRL_RESET;
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= RESP_OKAY;
            if (awaddr_q == ADDR_W'(ADDR_CTRL)) begin
                if (wstrb_q[0]) begin
                    ctrl <= wdata_q[CTRL_W-1:0];
                end
            end else if (awaddr_q != ADDR_W'(ADDR_STATUS)) begin
                bresp <= RESP_DECERR;
            end
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    status_t status;

    always_comb begin
        status                  = '0;
        status.pin_level        = {temp_warn_n_i, temp_warn_high_n_i,
                                   temp_warn_low_n_i, shutdown_flag_n_i};
        status.osc_slave        = osc_slave;
        status.thermal_latched  = therm_q;
        status.overload_latched = |ovl_q;
        status.hiz              = hb_hiz;
        status.state            = state;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= RESP_OKAY;
            if (araddr == ADDR_W'(ADDR_CTRL)) begin
                rdata <= 32'(ctrl);
            end else if (araddr == ADDR_W'(ADDR_STATUS)) begin
                rdata <= status;
            end else begin
                rdata <= '0;
                rresp <= RESP_DECERR;
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_uv_hiz;
        (uv_s && rst_s) |=> (&hb_hiz && shutdown_flag_n_oe);
    endproperty
    a_uv_hiz: assert property (p_uv_hiz) else $error("undervoltage not shut down");

    property p_group;
        (!parallel_bridge_config && local_s[0] && $stable(ctrl)) |=> (hb_hiz[1:0] == 2'b11);
    endproperty
    a_group: assert property (p_group) else $error("pair not disabled");

    property p_parallel_bridge_config_all;
        (parallel_bridge_config && (|local_s) && $stable(ctrl)) |=> &hb_hiz;
    endproperty
    a_parallel_bridge_config_all: assert property (p_parallel_bridge_config_all) else $error("parallel fault not global");

    property p_bst_only;
        (state == ST_RUN && next_state == ST_RUN && bst_s == 4'h4 && loc == 4'h0
            && !uv_s && !therm_q) |=> (hb_hiz == 4'h4 && !shutdown_flag_n_oe);
    endproperty
    a_bst_only: assert property (p_bst_only) else $error("bootstrap uv spread");

    sequence s_gnd_step;
        state == ST_PSC_GND;
    endsequence
    sequence s_pvdd_entry;
        state == ST_PSC_PVDD;
    endsequence

    property p_psc_order;
        $rose(state == ST_PSC_PVDD) |-> $past(state == ST_PSC_GND);
    endproperty
    a_psc_order: assert property (p_psc_order) else $error("check steps out of order");

    property p_psc_short_hold;
        (s_gnd_step ##0 sh_gnd_s) |=> (s_gnd_step ##0 cnt == 32'd0);
    endproperty
    a_psc_short_hold: assert property (p_psc_short_hold) else $error("short not held");

    property p_psc_sd;
        (s_gnd_step or s_pvdd_entry) |=> shutdown_flag_n_oe;
    endproperty
    a_psc_sd: assert property (p_psc_sd) else $error("shutdown released in check");

    property p_no_recheck;
        (state == ST_HOLD || state == ST_RUN || state == ST_START) |=> !psc_busy;
    endproperty
    a_no_recheck: assert property (p_no_recheck) else $error("check restarted");

    property p_se_skip;
        (state == ST_POR && se) |=> !psc_busy;
    endproperty
    a_se_skip: assert property (p_se_skip) else $error("check ran single-ended");

    sequence s_held_low;
        (state == ST_RUN && !rst_s) ##1 !rst_s;
    endsequence

    property p_reset_hold;
        (s_held_low ##0 $stable(ctrl)) |=> (&hb_hiz && !shutdown_flag_n_oe
                                            && hb_pulldown[0] == !se);
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset hold wrong");

    property p_therm;
        t_shut_s |=> (therm_q ##1 &hb_hiz);
    endproperty
    a_therm: assert property (p_therm) else $error("thermal shutdown not latched");

endmodule // amp_fault_protection_ctrl

// ---- test/flag_ctrl_model.sv ----
module flag_ctrl_model #(
    parameter int MIN_GAP = 80000
) (
    input  wire logic aclk,
    input  wire logic hold_low,
    input  wire logic sd_o,
    input  wire logic sd_oe,
    input  wire logic wl_o,
    input  wire logic wl_oe,
    input  wire logic wh_o,
    input  wire logic wh_oe,
    input  wire logic w_o,
    input  wire logic w_oe,
    output logic      reset_pin_n,
    output logic      sd_n,
    output logic      wl_n,
    output logic      wh_n,
    output logic      w_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int   gap = MIN_GAP;
    logic sd_q = 1'b1;
    // Pull-ups win whenever nobody pulls low
    assign sd_n = sd_oe ? sd_o : 1'b1;
    assign wl_n = wl_oe ? wl_o : 1'b1;
    assign wh_n = wh_oe ? wh_o : 1'b1;
    assign w_n  = w_oe ? w_o : 1'b1;
    initial reset_pin_n = 1'b1;
    always @(posedge aclk) begin
        sd_q <= sd_n;
        if (sd_q && !sd_n)
            gap <= 0;
        else if (gap < MIN_GAP)
            gap <= gap + 1;
        if (hold_low)
            reset_pin_n <= 1'b0;
        else if (gap >= MIN_GAP)
            reset_pin_n <= 1'b1; // Cool-down before release
    end
endmodule // flag_ctrl_model

// ---- test/amp_fault_protection_ctrl_test.sv ----
module amp_fault_protection_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, rst_hold = 0, rst_n;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [3:0] lf = 0, ol = 0, bs = 0, hiz, pd, f;
    logic uv = 0, t_lo = 0, t_wr = 0, t_sh = 0, s_g = 0, strap = 0, osc_en, osc_in;
    logic sd_o, sd_oe, wl_o, wl_oe, wh_o, wh_oe, w_o, w_oe, sd_n, wl_n, wh_n, w_n;
    int error_cnt = 0, comparisons = 0;
    always #25 aclk = ~aclk;
    amp_fault_protection_ctrl #(.PSC_STEP_CYCLES(8)) amp_fault_protection_ctrl_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .reset_pin_n(rst_n), .local_fault(lf),
        .overload_trip(ol), .bootstrap_uv(bs), .undervoltage_trip(uv),
        .temp_above_low(t_lo), .temp_above_warn(t_wr), .temp_above_shut(t_sh),
        .short_to_gnd(s_g), .short_to_supply(1'b0), .freq_trim_pin_at_reg(strap),
        .shutdown_flag_n_i(sd_n), .temp_warn_low_n_i(wl_n), .temp_warn_high_n_i(wh_n),
        .temp_warn_n_i(w_n), .shutdown_flag_n_o(sd_o), .shutdown_flag_n_oe(sd_oe),
        .temp_warn_low_n_o(wl_o), .temp_warn_low_n_oe(wl_oe), .temp_warn_high_n_o(wh_o),
        .temp_warn_high_n_oe(wh_oe), .temp_warn_n_o(w_o), .temp_warn_n_oe(w_oe),
        .hb_hiz(hiz), .hb_pulldown(pd), .osc_internal_en(osc_en), .osc_pins_input(osc_in));
    flag_ctrl_model #(.MIN_GAP(16)) flag_ctrl_model_i (
        .aclk(aclk), .hold_low(rst_hold), .sd_o(sd_o), .sd_oe(sd_oe), .wl_o(wl_o),
        .wl_oe(wl_oe), .wh_o(wh_o), .wh_oe(wh_oe), .w_o(w_o), .w_oe(w_oe),
        .reset_pin_n(rst_n), .sd_n(sd_n), .wl_n(wl_n), .wh_n(wh_n), .w_n(w_n));
    task automatic chk(logic [31:0] s, logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge aclk);
    endtask
    task automatic axi_wr(logic [7:0] a, logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        rs = bresp;
        bready <= 0;
    endtask
    task automatic axi_rd(logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        v = rdata; rs = rresp;
        rready <= 0;
    endtask
    // Bounded wait for switching to start
    task automatic wait_run();
        for (int n = 0; n < 200 && hiz !== 4'h0; n++) @(negedge aclk);
        chk(hiz, 4'h0);
    endtask
    task automatic pin_reset();
        @(posedge aclk); rst_hold <= 1;
        tick(5);
        @(posedge aclk); rst_hold <= 0;
        wait_run();
    endtask
    function automatic logic [3:0] grp(logic [3:0] x, logic par);
        if (par) return (x != 0) ? 4'hf : 4'h0;
        return {{2{|x[3:2]}}, {2{|x[1:0]}}};
    endfunction
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        void'($urandom(47));
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        tick(1); chk(hiz, 4'hf); chk(osc_en, 1'b1);
        tick(5); chk(sd_oe, 1'b1);
        axi_rd(8'h00, d, r); chk(d, 32'h4); chk(r, 2'h0);
        axi_rd(8'h08, d, r); chk(d, 32'h0); chk(r, 2'h3);
        axi_wr(8'h0c, 32'h1, r); chk(r, 2'h3);
        wait_run(); chk(sd_oe, 1'b0);
        axi_rd(8'h04, d, r); chk(d[5:0], 6'h20);
        $display("test startup done");
        for (int c = 0; c < 2; c++) begin
            axi_wr(8'h00, 32'h4 | c, r);
            wait_run();
            for (int k = 0; k < 8; k++) begin
                f = (k < 4) ? 4'h1 << k : 4'($urandom);
                @(posedge aclk); lf <= f;
                tick(5); chk(hiz, grp(f, c[0])); chk(sd_oe, f != 0);
                @(posedge aclk); lf <= 0;
                wait_run();
            end
        end
        $display("test local faults done");
        axi_wr(8'h00, 32'h4, r);
        for (int k = 0; k < 4; k++) begin
            f = 4'($urandom);
            @(posedge aclk); bs <= f;
            tick(5); chk(hiz, f); chk(sd_oe, 1'b0);
            @(posedge aclk); bs <= 0;
            tick(5); chk(hiz, 4'h0);
        end
        @(posedge aclk); uv <= 1; s_g <= 1;
        tick(5); chk(hiz, 4'hf); chk(sd_oe, 1'b1);
        @(posedge aclk); uv <= 0;
        wait_run();
        f = 4'h1 << ($urandom % 4);
        @(posedge aclk); s_g <= 0; ol <= f;
        tick(5); chk(sd_oe, 1'b1);
        @(posedge aclk); ol <= 0;
        tick(5); chk(hiz, grp(f, 1'b0));
        @(posedge aclk); rst_hold <= 1;
        tick(6); chk(sd_oe, 1'b0); chk(hiz, 4'hf); chk(pd, 4'hf);
        @(posedge aclk); rst_hold <= 0;
        for (int n = 0; n < 40 && rst_n !== 1'b1; n++) @(negedge aclk);
        tick(5); chk(sd_oe, 1'b0);
        wait_run();
        $display("test overload done");
        @(posedge aclk); t_lo <= 1;
        tick(5); chk(wl_oe, 1'b1); chk(wh_oe, 1'b0);
        @(posedge aclk); t_wr <= 1; t_sh <= 1;
        tick(5); chk(wh_oe, 1'b1); chk(hiz, 4'hf); chk(sd_oe, 1'b1);
        @(posedge aclk); t_lo <= 0; t_wr <= 0; t_sh <= 0;
        tick(5); chk(hiz, 4'hf);
        pin_reset();
        axi_wr(8'h00, 32'h0, r);
        @(posedge aclk); t_wr <= 1;
        tick(5); chk(w_oe, 1'b1); chk(wl_oe, 1'b0);
        @(posedge aclk); t_sh <= 1;
        tick(5); chk(hiz, 4'hf);
        @(posedge aclk); t_wr <= 0; t_sh <= 0;
        tick(5); chk(hiz, 4'hf);
        pin_reset();
        axi_wr(8'h00, 32'h2, r);
        @(posedge aclk); rst_hold <= 1;
        tick(6); chk(pd, 4'h0); chk(hiz, 4'hf);
        @(posedge aclk); rst_hold <= 0;
        wait_run();
        $display("test thermal and reset done");
        @(posedge aclk); aresetn <= 0; strap <= 1; s_g <= 1;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        tick(60); chk(hiz, 4'hf); chk(sd_oe, 1'b1);
        chk(osc_en, 1'b0); chk(osc_in, 1'b1);
        @(posedge aclk); s_g <= 0;
        wait_run();
        $display("test pin short done");
        wrap_up();
    end
endmodule // amp_fault_protection_ctrl_test
